// ### rtl/usc_params.svh
// constants for the second serial port control block
`ifndef USC_PARAMS_SVH
`define USC_PARAMS_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define USC_CTRL_ADDR      8'hd8
`define USC_CTRL_RESET     8'h00
`define USC_UNMAPPED_READ  8'h00

// ------------------------------------------------------------
// control register field positions
// ------------------------------------------------------------
`define USC_MODE_HIGH_BIT  7
`define USC_MODE_LOW_BIT   6
`define USC_MP_CHECK_BIT   5
`define USC_RX_EN_BIT      4
`define USC_TX_NINTH_BIT   3
`define USC_RX_NINTH_BIT   2
`define USC_TX_DONE_BIT    1
`define USC_RX_DONE_BIT    0

// ------------------------------------------------------------
// receive buffer shape
// ------------------------------------------------------------
`define USC_FIFO_WIDTH     9
`define USC_FIFO_DEPTH     4

`endif

// ### rtl/usc_pkg.sv
// types shared by the serial port control block
package usc_pkg;

    typedef enum logic [1:0] {
        USC_MODE0,
        USC_MODE1,
        USC_MODE2,
        USC_MODE3
    } usc_mode_e;

    typedef logic [7:0] usc_byte_t;

    // register state of the control block; the receive buffer keeps its own
    typedef struct packed {
        usc_byte_t ctrl;
        usc_byte_t rdata;
    } usc_ctrl_state_s;

endpackage : usc_pkg

// ### rtl/usc_fifo_if.sv
// push and pop handshake bundle between control block and its buffer
`timescale 1ns/1ns
`default_nettype none

interface usc_fifo_if #(
    parameter int WIDTH = 9
);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport fifo (
        input  push_valid,
        output push_ready,
        input  push_data,
        output pop_valid,
        input  pop_ready,
        output pop_data
    );

    modport user (
        output push_valid,
        input  push_ready,
        output push_data,
        input  pop_valid,
        output pop_ready,
        input  pop_data
    );
endinterface : usc_fifo_if

`default_nettype wire

// ### rtl/usc_fifo.sv
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none

module usc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic  clk,
    input wire logic  rst_b,
    usc_fifo_if.fifo  f
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } usc_fifo_state_s;

    usc_fifo_state_s st_q;
    usc_fifo_state_s st_d;
    logic            push;
    logic            pop;

    // ------------------------------------------------------------
    // handshakes
    // ------------------------------------------------------------
    assign f.push_ready = (st_q.cnt != (AW+1)'(DEPTH));
    assign f.pop_valid  = (st_q.cnt != '0);
    assign f.pop_data   = st_q.mem[st_q.rp];
    assign push         = f.push_valid && f.push_ready;
    assign pop          = f.pop_valid && f.pop_ready;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wp] = f.push_data;
            st_d.wp = (st_q.wp == AW'(DEPTH - 1)) ? '0 : st_q.wp + AW'(1);
        end
        if (pop) begin
            st_d.rp = (st_q.rp == AW'(DEPTH - 1)) ? '0 : st_q.rp + AW'(1);
        end
        if (push && !pop) begin
            st_d.cnt = st_q.cnt + (AW+1)'(1);
        end else if (pop && !push) begin
            st_d.cnt = st_q.cnt - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : usc_fifo // usc_fifo

`default_nettype wire

// ### rtl/usc_serial_ctrl.sv
// control and status register block of the second serial port
//
// What this block does
// - bits 7:6 pick mode, bit 7 high: 00 mode0 .. 11 mode3
// - mode 1, check clear: stop bit level ignored for receive-done
// - mode 1, check set: receive-done only when stop bit is one
// - modes 2/3, check clear: ninth bit ignored for receive-done
// - modes 2/3, check set: receive-done only when ninth bit is one
// - mode 0 transmit: transmit-done set at end of eighth bit time
// - modes 1-3 transmit: transmit-done set as stop bit starts; software clears
// - mode 0 receive: receive-done set at end of eighth bit time
// - modes 1-3 receive: receive-done set mid stop bit, subject to check
// - receive-done never cleared by hardware; software writes zero
// - modes 2/3: ninth received bit stored in received-ninth-bit field
// - mode 1, check clear: stop bit level stored in received-ninth-bit field
// - control register at address d8h, resets to 00h
`timescale 1ns/1ns
`default_nettype none
`include "usc_params.svh"

module usc_serial_ctrl
    import usc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    output logic      [1:0] mode_sel,
    output logic            rx_enable,
    output logic            multiproc_check_enable,
    output logic            tx_ninth_bit,
    input  wire logic       tx_bit8_end,
    input  wire logic       tx_stop_start,
    input  wire logic       rx_frame_valid,
    output logic            rx_frame_ready,
    input  wire logic [7:0] rx_frame_data,
    input  wire logic       rx_frame_bit9,
    output logic            rx_word_valid,
    input  wire logic       rx_word_ready,
    output logic      [8:0] rx_word_data,
    output logic            tx_done_flag,
    output logic            rx_done_flag
);
    usc_ctrl_state_s st_q;
    usc_ctrl_state_s st_d;
    usc_mode_e       mode;
    logic            ctrl_hit;
    logic            mp_check;
    logic            rx_en;
    logic            frame_ok;
    logic            frame_take;
    logic            frame_keep;
    logic            tx_event;

    usc_fifo_if #(.WIDTH(`USC_FIFO_WIDTH)) rxq ();

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    assign mode     = usc_mode_e'({st_q.ctrl[`USC_MODE_HIGH_BIT],
                                   st_q.ctrl[`USC_MODE_LOW_BIT]});
    assign mp_check = st_q.ctrl[`USC_MP_CHECK_BIT];
    assign rx_en    = st_q.ctrl[`USC_RX_EN_BIT];
    assign ctrl_hit = (sfr_addr == `USC_CTRL_ADDR);

    // ------------------------------------------------------------
    // frame qualification
    // ------------------------------------------------------------
    // check bit has no effect in mode 0, software keeps it low there
    always_comb begin
        unique case (mode)
            USC_MODE0: frame_ok = 1'b1;
            USC_MODE1: frame_ok = !mp_check || rx_frame_bit9;
            USC_MODE2,
            USC_MODE3: frame_ok = !mp_check || rx_frame_bit9;
        endcase
    end

    // disabled receiver swallows frames so the shifter never hangs
    assign rx_frame_ready = !rx_en || rxq.push_ready;
    assign frame_take     = rx_frame_valid && rx_frame_ready;
    assign frame_keep     = frame_take && rx_en && frame_ok;

    assign rxq.push_valid = rx_frame_valid && rx_en && frame_ok;
    assign rxq.push_data  = {rx_frame_bit9 && (mode != USC_MODE0), rx_frame_data};
    assign rxq.pop_ready  = rx_word_ready;
    assign rx_word_valid  = rxq.pop_valid;
    assign rx_word_data   = rxq.pop_data;

    // ------------------------------------------------------------
    // transmit completion
    // ------------------------------------------------------------
    assign tx_event = (mode == USC_MODE0) ? tx_bit8_end
                                          : tx_stop_start;

    // ------------------------------------------------------------
    // register next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (sfr_wr && ctrl_hit) begin
            st_d.ctrl = sfr_wdata;
        end
        // hardware sets win over a same-cycle software clear
        if (tx_event) begin
            st_d.ctrl[`USC_TX_DONE_BIT] = 1'b1;
        end
        if (frame_keep) begin
            st_d.ctrl[`USC_RX_DONE_BIT] = 1'b1;
            if (mode == USC_MODE2 || mode == USC_MODE3) begin
                st_d.ctrl[`USC_RX_NINTH_BIT] = rx_frame_bit9;
            end else if (mode == USC_MODE1 && !mp_check) begin
                st_d.ctrl[`USC_RX_NINTH_BIT] = rx_frame_bit9;
            end
        end
        if (sfr_rd) begin
            st_d.rdata = ctrl_hit ? st_q.ctrl : `USC_UNMAPPED_READ;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q.ctrl  <= `USC_CTRL_RESET;
            st_q.rdata <= 8'h00;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // receive buffer
    // ------------------------------------------------------------
    usc_fifo #(
        .WIDTH (`USC_FIFO_WIDTH),
        .DEPTH (`USC_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk   (clk),
        .rst_b (rst_b),
        .f     (rxq.fifo)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign sfr_rdata              = st_q.rdata;
    assign mode_sel               = {st_q.ctrl[`USC_MODE_HIGH_BIT],
                                     st_q.ctrl[`USC_MODE_LOW_BIT]};
    assign rx_enable              = rx_en;
    assign multiproc_check_enable = mp_check;
    assign tx_ninth_bit           = st_q.ctrl[`USC_MODE_HIGH_BIT]
                                    && st_q.ctrl[`USC_TX_NINTH_BIT];
    assign tx_done_flag           = st_q.ctrl[`USC_TX_DONE_BIT];
    assign rx_done_flag           = st_q.ctrl[`USC_RX_DONE_BIT];
endmodule : usc_serial_ctrl // usc_serial_ctrl

`default_nettype wire

// ### bench/usc_serial_ctrl_assertions.sv
// checker on the ports of the serial port control block
`timescale 1ns/1ns
`default_nettype none
module usc_serial_ctrl_chk (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [1:0] mode_sel,
    input wire logic       multiproc_check_enable,
    input wire logic       rx_enable,
    input wire logic       tx_ninth_bit,
    input wire logic       tx_bit8_end,
    input wire logic       tx_stop_start,
    input wire logic       rx_frame_valid,
    input wire logic       rx_frame_ready,
    input wire logic       rx_frame_bit9,
    input wire logic       tx_done_flag,
    input wire logic       rx_done_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic wr;
    logic acc;
    logic quiet;
    assign wr    = sfr_wr && sfr_addr == 8'hd8;
    assign acc   = rx_frame_valid && rx_frame_ready;
    assign quiet = acc && !rx_done_flag && !wr;
    mode_field_a: assert property (wr |=> mode_sel == $past(sfr_wdata[7:6]))
        else $error("mode select differs from written field");
    ninth_tx_a: assert property (wr |=> tx_ninth_bit == $past(sfr_wdata[7] & sfr_wdata[3]))
        else $error("transmit ninth bit wrong");
    tx_mode0_a: assert property (tx_bit8_end && mode_sel == 2'h0 |=> tx_done_flag)
        else $error("transmit done missing in mode 0");
    tx_stop_a: assert property (tx_stop_start && mode_sel != 2'h0 |=> tx_done_flag)
        else $error("transmit done missing at stop bit");
    rx_hold_a: assert property (rx_done_flag && !wr |=> rx_done_flag)
        else $error("receive done cleared by hardware");
    rx_off_a: assert property (quiet && !rx_enable |=> !rx_done_flag)
        else $error("receive done set while disabled");
    mp_reject_a: assert property (quiet && rx_enable && multiproc_check_enable
        && mode_sel != 2'h0 && !rx_frame_bit9 |=> !rx_done_flag)
        else $error("frame kept despite check");
    rx_set_a: assert property (acc && rx_enable
        && (!multiproc_check_enable || rx_frame_bit9 || mode_sel == 2'h0) |=> rx_done_flag)
        else $error("receive done not set");
endmodule // usc_serial_ctrl_chk
bind usc_serial_ctrl usc_serial_ctrl_chk usc_serial_ctrl_chk_i (.clk, .rst_b, .sfr_addr,
    .sfr_wr, .sfr_wdata, .mode_sel, .multiproc_check_enable, .rx_enable, .tx_ninth_bit,
    .tx_bit8_end, .tx_stop_start, .rx_frame_valid, .rx_frame_ready, .rx_frame_bit9,
    .tx_done_flag, .rx_done_flag);
`default_nettype wire

// ### bench/usc_peer_model.sv
// model of the receive and transmit shifter facing the block
`timescale 1ns/1ns
`default_nettype none
module usc_peer_model (
    input  wire logic       clk,
    input  wire logic       rx_frame_ready,
    output logic            rx_frame_valid,
    output logic      [7:0] rx_frame_data,
    output logic            rx_frame_bit9,
    output logic            tx_bit8_end,
    output logic            tx_stop_start
);
    initial begin
        {rx_frame_valid, rx_frame_data, rx_frame_bit9, tx_bit8_end, tx_stop_start} = '0;
    end
    // holds the frame until ready is seen at a falling edge, giving up after 50 cycles
    task automatic send(input logic [7:0] d, input logic b, output logic ok);
        logic r;
        int   n;
        @(posedge clk);
        #1;
        {rx_frame_valid, rx_frame_data, rx_frame_bit9} = {1'b1, d, b};
        r = 0;
        n = 0;
        while (!r && n < 50) begin
            @(negedge clk);
            r = rx_frame_ready;
            @(posedge clk);
            n++;
        end
        #1;
        {rx_frame_valid, rx_frame_data, rx_frame_bit9} = {1'b0, ~d, ~b};
        ok = r;
    endtask
    task automatic pulse(input logic s);
        @(posedge clk);
        #1;
        {tx_stop_start, tx_bit8_end} = {s, !s};
        @(posedge clk);
        #1;
        {tx_stop_start, tx_bit8_end} = 2'h0;
    endtask
endmodule // usc_peer_model
`default_nettype wire

// ### bench/test_usc_serial_ctrl.sv
// testbench of the serial port control block
`timescale 1ns/1ns
`default_nettype none
module test_usc_serial_ctrl;
    logic       clk = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0, rx_word_ready = 0;
    logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, rx_frame_data;
    logic [1:0] mode_sel;
    logic [8:0] rx_word_data;
    logic       rx_enable, multiproc_check_enable, tx_ninth_bit, tx_bit8_end, tx_stop_start;
    logic       rx_frame_valid, rx_frame_ready, rx_frame_bit9, rx_word_valid;
    logic       tx_done_flag, rx_done_flag;
    logic [5:0] cs [9] = '{6'h12, 6'h18, 6'h1e, 6'h17, 6'h22, 6'h28, 6'h3f, 6'h37, 6'h06};
    logic [5:0] c;
    logic [7:0] w;
    logic       ok;
    int         error_cnt = 0, check_count = 0;
    always #5 clk = ~clk;
    usc_serial_ctrl usc_serial_ctrl_i (.clk, .rst_b, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
        .sfr_rdata, .mode_sel, .rx_enable, .multiproc_check_enable, .tx_ninth_bit,
        .tx_bit8_end, .tx_stop_start, .rx_frame_valid, .rx_frame_ready, .rx_frame_data,
        .rx_frame_bit9, .rx_word_valid, .rx_word_ready, .rx_word_data, .tx_done_flag,
        .rx_done_flag);
    usc_peer_model usc_peer_model_i (.clk, .rx_frame_ready, .rx_frame_valid, .rx_frame_data,
        .rx_frame_bit9, .tx_bit8_end, .tx_stop_start);
    task chk(input string n, input logic [8:0] e, input logic [8:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
        @(posedge clk);
        #1;
        sfr_wr = 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #1;
        {sfr_rd, sfr_addr} = {1'b1, a};
        @(posedge clk);
        #1;
        sfr_rd = 0;
        chk("rdata", e, sfr_rdata);
    endtask
    task pop;
        @(posedge clk);
        #1;
        rx_word_ready = 1;
        @(posedge clk);
        #1;
        rx_word_ready = 0;
    endtask
    task give_verdict;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        give_verdict;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst_b = 1;
        rd(8'hd8, 8'h00);
        foreach (cs[i]) begin
            c = cs[i];
            w = {c[5:3], 2'h3, 3'h0}; // check bit kept low in mode 0
            wr(8'hd8, w);
            chk("mode", c[5:4], mode_sel);
            chk("tx_ninth", c[5], tx_ninth_bit);
            chk("check_en", c[3], multiproc_check_enable);
            chk("rx_en", 1, rx_enable);
            usc_peer_model_i.send(8'h5a, c[2], ok);
            chk("accepted", 1, ok);
            rd(8'hd8, w | {5'h0, c[0], 1'b0, c[1]});
            chk("word_valid", c[1], rx_word_valid);
            if (c[1]) begin
                chk("word", {(c[5] | c[4]) & c[2], 8'h5a}, rx_word_data);
                pop;
            end
        end
        wr(8'hd8, 8'h40);
        usc_peer_model_i.send(8'h33, 1'b1, ok);
        chk("accepted_off", 1, ok);
        chk("rx_off", 0, rx_done_flag);
        chk("word_off", 0, rx_word_valid);
        wr(8'h99, 8'hff);
        rd(8'hd8, 8'h40);
        rd(8'h99, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(8'hd8, {m[1:0], 6'h0});
            chk("tx_ninth_clr", 0, tx_ninth_bit);
            usc_peer_model_i.pulse(m == 0);
            chk("tx_other", 0, tx_done_flag);
            usc_peer_model_i.pulse(m != 0);
            chk("tx_done", 1, tx_done_flag);
        end
        wr(8'hd8, 8'h50);
        for (int k = 0; k < 4; k++) begin
            usc_peer_model_i.send(k[7:0], 1'b1, ok);
            chk("accepted_fill", 1, ok);
        end
        chk("full", 0, rx_frame_ready);
        for (int k = 0; k < 4; k++) begin
            chk("drain", {1'b1, k[7:0]}, rx_word_data);
            pop;
        end
        chk("empty", 0, rx_word_valid);
        rd(8'hd8, 8'h55);
        // mid-run reset with a word left in the buffer
        usc_peer_model_i.send(8'hc3, 1'b1, ok);
        chk("accepted_last", 1, ok);
        chk("word_left", 1, rx_word_valid);
        @(posedge clk);
        #1;
        rst_b = 0;
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1;
        rd(8'hd8, 8'h00);
        chk("word_reset", 0, rx_word_valid);
        chk("ready_reset", 1, rx_frame_ready);
        chk("mode_reset", 0, mode_sel);
        give_verdict;
    end
endmodule // test_usc_serial_ctrl
`default_nettype wire
